// *** rstm_pkg.sv ***
`default_nettype none
package rstm_pkg;
    // host i/o address of the global enable port
    localparam logic [15:0] GEN_PORT_ADDR    = 16'h46e8;
    // field positions inside the global enable port
    localparam int          GEN_SETUP_BIT    = 4;
    localparam int          GEN_ENABLE_BIT   = 3;
    localparam logic [7:0]  GEN_RESET_VAL    = 8'h00;
    // decode-disable bit position in the port decode control register
    localparam int          DEC_OFF_BIT      = 0;
    localparam logic [7:0]  DEC_RESET_VAL    = 8'h00;
    // minimum reset pulse, in ps, and its cycle count at 200 MHz
    localparam int          RST_MIN_PS       = 1_500_000;
    localparam int          CLK_PERIOD_PS    = 5_000;
    localparam int          RST_MIN_CYC      =
        (RST_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    // number of pins in the nand test ring
    localparam int          RING_PINS        = 8;
    localparam int          STRAP_W          = 16;
    localparam int          TEST_STRAP_BIT   = 15;
    localparam int          HOST_TRIS_W      = 8;

    typedef enum logic [1:0]
    {
        RSTM_RESET  = 2'b00,
        RSTM_ICT    = 2'b01,
        RSTM_NORMAL = 2'b10,
        RSTM_SETUP  = 2'b11
    } rstm_mode_type;
endpackage : rstm_pkg
`default_nettype wire

// *** rstm_strap_latch.sv ***
`timescale 1ns/10ps
`default_nettype none
module rstm_strap_latch
#(
    parameter int STRAP_W = rstm_pkg::STRAP_W
)
(
    input  wire logic               i_mclk,
    input  wire logic               i_srst,
    input  wire logic [STRAP_W-1:0] i_straps,
    output logic      [STRAP_W-1:0] o_straps,
    output logic                    o_fall
);
    logic               rst_d_ff;
    logic [STRAP_W-1:0] strap_ff;

    // remember the previous reset level to spot its falling edge
    always_ff @(posedge i_mclk)
    begin
        rst_d_ff <= i_srst;
    end

    // straps are sampled while reset is high; the last sample is kept
    always_ff @(posedge i_mclk)
    begin
        if (i_srst)
        begin
            strap_ff <= i_straps;
        end
    end

    assign o_straps = strap_ff;
    assign o_fall   = rst_d_ff & ~i_srst;
endmodule // rstm_strap_latch
`default_nettype wire

// *** rstm_nand_ring.sv ***
`timescale 1ns/10ps
`default_nettype none
module rstm_nand_ring
#(
    parameter int N = rstm_pkg::RING_PINS
)
(
    input  wire logic         i_mclk,
    input  wire logic [N-1:0] i_pins,
    output logic              o_ring
);
    logic [N:0] chain;

    // each stage nands the running result with its pin; with pins high and
    // brought low in ring order, each fall flips the tail
    assign chain[0] = 1'b1;
    genvar g;
    generate
        for (g = 0; g < N; g++)
        begin : g_stage
            assign chain[g+1] = ~(chain[g] & i_pins[g]);
        end
    endgenerate

    // registered so the pin output comes from a flop
    always_ff @(posedge i_mclk)
    begin
        o_ring <= chain[N];
    end
endmodule // rstm_nand_ring
`default_nettype wire

// *** rstm_top.sv ***
`timescale 1ns/10ps
`default_nettype none
module rstm_top
#(
    parameter int RING_PINS = rstm_pkg::RING_PINS,
    parameter int STRAP_W   = rstm_pkg::STRAP_W,
    parameter int OUT_W     = rstm_pkg::HOST_TRIS_W
)
(
    input  wire logic                 i_mclk,
    input  wire logic                 i_srst,
    input  wire logic [15:0]          i_io_addr,
    input  wire logic [7:0]           i_io_wdata,
    input  wire logic                 i_io_wr,
    input  wire logic                 i_io_rd,
    input  wire logic [STRAP_W-1:0]   i_mem_data_straps,
    input  wire logic [RING_PINS-1:0] i_ring_pins,
    input  wire logic [OUT_W-1:0]     i_func_out,
    input  wire logic                 i_func_we_n,
    input  wire logic                 i_func_video_on,
    input  wire logic                 i_dec_wr,
    input  wire logic [7:0]           i_dec_wdata,
    output logic      [7:0]           o_io_rdata,
    output logic                      o_io_rd_hit,
    output logic                      o_other_reg_en,
    output logic                      o_dev_enable,
    output logic                      o_vga_compat,
    output logic                      o_setup_mode,
    output logic                      o_ict_mode,
    output logic                      o_video_on,
    output logic      [OUT_W-1:0]     o_pins_out,
    output logic      [OUT_W-1:0]     o_pins_oe,
    output logic                      o_we_n_out,
    output logic                      o_we_n_oe,
    output logic      [STRAP_W-1:0]   o_straps,
    output logic      [7:0]           o_port_decode_ctrl_reg
);
    logic [7:0]         gen_ff;
    logic [7:0]         dec_ff;
    logic               video_ff;
    logic               ict_now;
    logic               ring_out;
    logic               strap_fall;
    logic [STRAP_W-1:0] straps;
    logic               gen_hit;
    rstm_pkg::rstm_mode_type mode_ff;

    // address decode reused by reads and writes
    function automatic logic port_hit(input logic [15:0] a, input logic off);
        port_hit = (a == rstm_pkg::GEN_PORT_ADDR) && !off;
    endfunction

    assign gen_hit = port_hit(i_io_addr,
                              dec_ff[rstm_pkg::DEC_OFF_BIT]);

    rstm_strap_latch #(.STRAP_W(STRAP_W)) u_strap
    (
        .i_mclk   (i_mclk),
        .i_srst   (i_srst),
        .i_straps (i_mem_data_straps),
        .o_straps (straps),
        .o_fall   (strap_fall)
    );

    rstm_nand_ring #(.N(RING_PINS)) u_ring
    (
        .i_mclk (i_mclk),
        .i_pins (i_ring_pins),
        .o_ring (ring_out)
    );

    // captured straps published once reset has fallen
    always_ff @(posedge i_mclk)
    begin
        if (strap_fall)
        begin
            o_straps <= straps;
        end
    end

    // global enable port; reset clears enable and setup
    always_ff @(posedge i_mclk)
    begin
        if (i_srst)
        begin
            gen_ff <= rstm_pkg::GEN_RESET_VAL;
        end
        else if (i_io_wr && gen_hit)
        begin
            gen_ff <= i_io_wdata;
        end
    end

    // decode control sits in the extension set, written by the core
    always_ff @(posedge i_mclk)
    begin
        if (i_srst)
        begin
            dec_ff <= rstm_pkg::DEC_RESET_VAL;
        end
        else if (i_dec_wr)
        begin
            dec_ff <= i_dec_wdata;
        end
    end

    // mode tracking; ict depends on the live strap level during reset
    always_ff @(posedge i_mclk)
    begin
        if (i_srst)
        begin
            if (!i_mem_data_straps[rstm_pkg::TEST_STRAP_BIT])
            begin
                mode_ff <= rstm_pkg::RSTM_ICT;
            end
            else
            begin
                mode_ff <= rstm_pkg::RSTM_RESET;
            end
        end
        else if (i_io_wr && gen_hit)
        begin
            if (i_io_wdata[rstm_pkg::GEN_SETUP_BIT])
            begin
                mode_ff <= rstm_pkg::RSTM_SETUP;
            end
            else
            begin
                mode_ff <= rstm_pkg::RSTM_NORMAL;
            end
        end
        else if (mode_ff == rstm_pkg::RSTM_ICT)
        begin
            mode_ff <= rstm_pkg::RSTM_RESET;  // device stays disabled
        end
    end

    // video state frozen while in setup, cleared by reset
    always_ff @(posedge i_mclk)
    begin
        if (i_srst)
        begin
            video_ff <= 1'b0;
        end
        else if (mode_ff != rstm_pkg::RSTM_SETUP)
        begin
            video_ff <= i_func_video_on & o_dev_enable;
        end
        // setup holds previous level
    end

    // status outputs, registered
    always_ff @(posedge i_mclk)
    begin
        if (i_srst)
        begin
            o_dev_enable   <= 1'b0;
            o_vga_compat   <= 1'b1;
            o_setup_mode   <= 1'b0;
            o_other_reg_en <= 1'b0;
        end
        else
        begin
            // a hitting write wins, so clearing enable is not lost a cycle
            o_dev_enable   <= (i_io_wr && gen_hit) ?
                              i_io_wdata[rstm_pkg::GEN_ENABLE_BIT] :
                              gen_ff[rstm_pkg::GEN_ENABLE_BIT];
            o_vga_compat   <= o_vga_compat;
            o_setup_mode   <= (mode_ff == rstm_pkg::RSTM_SETUP);
            // other registers muted in setup
            o_other_reg_en <= (mode_ff == rstm_pkg::RSTM_NORMAL) &&
                              gen_ff[rstm_pkg::GEN_ENABLE_BIT];
        end
    end

    assign ict_now = (mode_ff == rstm_pkg::RSTM_ICT);

    // read path: only the enable port is visible here
    always_ff @(posedge i_mclk)
    begin
        if (i_srst)
        begin
            o_io_rdata  <= 8'h00;
            o_io_rd_hit <= 1'b0;
        end
        else
        begin
            o_io_rd_hit <= i_io_rd && gen_hit;
            o_io_rdata  <= (i_io_rd && gen_hit) ? gen_ff : 8'h00;
        end
    end

    // pad drive; tristate follows the reset pin with one flop delay
    always_ff @(posedge i_mclk)
    begin
        o_pins_out             <= i_func_out;
        o_pins_oe              <= {OUT_W{~i_srst}};
        o_ict_mode             <= i_srst &
                                  ~i_mem_data_straps[rstm_pkg::TEST_STRAP_BIT];
        o_video_on             <= video_ff;
        o_port_decode_ctrl_reg <= dec_ff;
    end

    // write-enable pin carries the ring result in test mode
    always_ff @(posedge i_mclk)
    begin
        if (ict_now)
        begin
            o_we_n_out <= ring_out;
            o_we_n_oe  <= 1'b1;
        end
        else
        begin
            o_we_n_out <= i_func_we_n;
            o_we_n_oe  <= ~i_srst;
        end
    end

    // checks
    sequence s_write_setup;
        i_io_wr && gen_hit && i_io_wdata[rstm_pkg::GEN_SETUP_BIT];
    endsequence

    property p_setup_enter;
        @(posedge i_mclk) disable iff (i_srst)
        s_write_setup |=> ##1 o_setup_mode;
    endproperty
    a_setup_enter: assert property (p_setup_enter)
        else $error("setup not entered");

    property p_setup_leave;
        @(posedge i_mclk) disable iff (i_srst)
        (i_io_wr && gen_hit && !i_io_wdata[rstm_pkg::GEN_SETUP_BIT])
            |=> ##1 !o_setup_mode;
    endproperty
    a_setup_leave: assert property (p_setup_leave)
        else $error("setup not left");

    property p_setup_mute;
        @(posedge i_mclk) o_setup_mode |-> !o_other_reg_en;
    endproperty
    a_setup_mute: assert property (p_setup_mute)
        else $error("other registers open in setup");

    property p_video_hold;
        @(posedge i_mclk) disable iff (i_srst)
        (mode_ff == rstm_pkg::RSTM_SETUP) |=> $stable(video_ff);
    endproperty
    a_video_hold: assert property (p_video_hold)
        else $error("video changed in setup");

    property p_reset_disable;
        @(posedge i_mclk) i_srst |=> !o_dev_enable && o_vga_compat;
    endproperty
    a_reset_disable: assert property (p_reset_disable)
        else $error("enabled during reset");

    property p_tris;
        @(posedge i_mclk) i_srst |=> (o_pins_oe == '0);
    endproperty
    a_tris: assert property (p_tris)
        else $error("outputs driven in reset");

    property p_untris;
        @(posedge i_mclk) $fell(i_srst) |=> (o_pins_oe == '1);
    endproperty
    a_untris: assert property (p_untris)
        else $error("outputs not released");

    property p_ict;
        @(posedge i_mclk)
        (i_srst && !i_mem_data_straps[rstm_pkg::TEST_STRAP_BIT])
            |=> o_ict_mode;
    endproperty
    a_ict: assert property (p_ict)
        else $error("test mode missed");

    property p_decode_off;
        @(posedge i_mclk) disable iff (i_srst)
        (dec_ff[rstm_pkg::DEC_OFF_BIT] && i_io_rd) |=> !o_io_rd_hit;
    endproperty
    a_decode_off: assert property (p_decode_off)
        else $error("port decoded while off");
endmodule // rstm_top
`default_nettype wire

// *** rstm_host_model.sv ***
`timescale 1ns/10ps
`default_nettype none
module rstm_host_model
(
    input  wire logic       i_mclk,
    input  wire logic [7:0] i_rdata,
    input  wire logic       i_hit,
    output logic            o_srst,
    output logic [15:0]     o_addr,
    output logic [7:0]      o_wdata,
    output logic            o_wr,
    output logic            o_rd,
    output logic [15:0]     o_straps,
    output logic [7:0]      o_ring
);
    // idle bus, reset asserted from time zero
    initial
    begin
        o_srst   = 1'b1;
        o_addr   = 16'h0000;
        o_wdata  = 8'h00;
        o_wr     = 1'b0;
        o_rd     = 1'b0;
        o_straps = 16'hffff;
        o_ring   = 8'hff;
    end

    // reset returns still asserted, after the hold span
    task automatic reset_on(input logic [15:0] s, input int cyc);
        @(posedge i_mclk);
        #1;
        o_srst   = 1'b1;
        o_straps = s;
        repeat (cyc) @(posedge i_mclk);
        #1;
    endtask

    // straps held one edge past release, then the bus moves on
    task automatic reset_off();
        @(posedge i_mclk);
        #1;
        o_srst = 1'b0;
        @(posedge i_mclk);
        #1;
        o_straps = ~o_straps;
    endtask

    // single byte write; lines parked inverted when released
    task automatic io_write(input logic [15:0] a, input logic [7:0] d);
        @(posedge i_mclk);
        #1;
        o_addr  = a;
        o_wdata = d;
        o_wr    = 1'b1;
        @(posedge i_mclk);
        #1;
        o_wr    = 1'b0;
        o_addr  = ~a;
        o_wdata = ~d;
    endtask

    // read; answer may land on either of two edges
    task automatic io_read(input logic [15:0] a, output logic [7:0] d,
                           output logic h);
        @(posedge i_mclk);
        #1;
        o_addr = a;
        o_rd   = 1'b1;
        @(posedge i_mclk);
        #1;
        o_rd   = 1'b0;
        o_addr = ~a;
        d      = i_rdata;
        h      = 1'b0;
        for (int k = 0; k < 2; k++)
        begin
            if (i_hit === 1'b1)
            begin
                h = 1'b1;
                d = i_rdata;
            end
            @(posedge i_mclk);
            #1;
        end
    endtask

    // ring stepping: all high first, then one pin low in ring order
    task automatic ring_high();
        @(posedge i_mclk);
        #1;
        o_ring = 8'hff;
    endtask

    task automatic ring_low(input int k);
        @(posedge i_mclk);
        #1;
        o_ring[k] = 1'b0;
    endtask
endmodule // rstm_host_model
`default_nettype wire

// *** tb_top.sv ***
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    logic        mclk;
    logic        srst;
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic        wr;
    logic        rd;
    logic [15:0] straps;
    logic [7:0]  ring;
    logic [7:0]  func_out = 8'h5a;
    logic        func_we_n = 1'b0;
    logic        vid_on = 1'b1;
    logic        dec_wr = 1'b0;
    logic [7:0]  dec_wdata = 8'h00;
    logic [7:0]  rdata;
    logic        hit;
    logic [7:0]  rd_d;
    logic        rd_h;
    logic        other_en;
    logic        dev_en;
    logic        vga;
    logic        setup;
    logic        ict;
    logic        video;
    logic [7:0]  pins_out;
    logic [7:0]  pins_oe;
    logic        we_out;
    logic        we_oe;
    logic [15:0] straps_q;
    logic [7:0]  dec_reg;
    logic        prev;
    int          failures = 0;
    int          checks_done = 0;
    localparam logic [15:0] GA = rstm_pkg::GEN_PORT_ADDR;

    initial
    begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end

    rstm_host_model u_host (.i_mclk(mclk), .i_rdata(rdata), .i_hit(hit),
        .o_srst(srst), .o_addr(addr), .o_wdata(wdata), .o_wr(wr),
        .o_rd(rd), .o_straps(straps), .o_ring(ring));

    rstm_top u_dut (.i_mclk(mclk), .i_srst(srst), .i_io_addr(addr),
        .i_io_wdata(wdata), .i_io_wr(wr), .i_io_rd(rd),
        .i_mem_data_straps(straps), .i_ring_pins(ring),
        .i_func_out(func_out), .i_func_we_n(func_we_n),
        .i_func_video_on(vid_on), .i_dec_wr(dec_wr),
        .i_dec_wdata(dec_wdata), .o_io_rdata(rdata), .o_io_rd_hit(hit),
        .o_other_reg_en(other_en), .o_dev_enable(dev_en),
        .o_vga_compat(vga), .o_setup_mode(setup), .o_ict_mode(ict),
        .o_video_on(video), .o_pins_out(pins_out), .o_pins_oe(pins_oe),
        .o_we_n_out(we_out), .o_we_n_oe(we_oe), .o_straps(straps_q),
        .o_port_decode_ctrl_reg(dec_reg));

    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        checks_done++;
        if (g !== e)
        begin
            failures++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    task automatic results();
        $display("checks=%0d failures=%0d", checks_done, failures);
        if (failures == 0 && checks_done > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // one decode control write from the core side
    task automatic dec_write(input logic [7:0] d);
        @(posedge mclk);
        #1;
        dec_wr    = 1'b1;
        dec_wdata = d;
        @(posedge mclk);
        #1;
        dec_wr    = 1'b0;
        @(posedge mclk);
        #1;
    endtask

    // hang guard, far beyond the few hundred cycles needed
    initial
    begin
        #(5 * 4000);
        failures++;
        results();
    end

    initial
    begin
        u_host.reset_on(16'ha5c3, 10);
        chk({pins_oe, we_oe}, 16'h0000);
        chk({dev_en, vga, setup}, 16'h0002);
        u_host.reset_off();
        chk(pins_oe, 16'h00ff);
        chk(pins_out, 16'h005a);
        chk({we_out, we_oe}, 16'h0001);
        chk(straps_q, 16'ha5c3);
        chk({dev_en, other_en, ict}, 16'h0000);
        u_host.io_read(GA, rd_d, rd_h);
        chk({rd_h, rd_d}, {8'h01, rstm_pkg::GEN_RESET_VAL});
        u_host.io_read(16'h03d6, rd_d, rd_h);
        chk({rd_h, rd_d}, 16'h0000);
        u_host.io_write(GA, 8'h08);
        repeat (2) @(posedge mclk);
        #1;
        chk({dev_en, other_en, video}, 16'h0007);
        u_host.io_write(GA, 8'h18);
        @(posedge mclk);
        #1;
        chk({setup, other_en}, 16'h0002);
        vid_on = 1'b0;
        repeat (3) @(posedge mclk);
        #1;
        chk(video, 16'h0001);
        u_host.io_read(GA, rd_d, rd_h);
        chk({rd_h, rd_d}, 16'h0118);
        u_host.io_write(GA, 8'h08);
        vid_on = 1'b1;
        @(posedge mclk);
        #1;
        chk({setup, other_en}, 16'h0001);
        dec_write(8'h01);
        chk(dec_reg, 16'h0001);
        u_host.io_write(GA, 8'h00);
        @(posedge mclk);
        #1;
        chk(dev_en, 16'h0001);
        u_host.io_read(GA, rd_d, rd_h);
        chk({rd_h, rd_d}, 16'h0000);
        dec_write(8'h00);
        u_host.io_read(GA, rd_d, rd_h);
        chk({rd_h, rd_d}, 16'h0108);
        u_host.reset_on(16'h7fff, rstm_pkg::RST_MIN_CYC);
        chk({ict, dev_en, vga, we_oe}, 16'h000b);
        u_host.ring_high();
        repeat (3) @(posedge mclk);
        #1;
        for (int k = 0; k < 8; k++)
        begin
            prev = we_out;
            u_host.ring_low(k);
            repeat (3) @(posedge mclk);
            #1;
            chk(we_out, {15'h0000, ~prev});
        end
        u_host.ring_high();
        u_host.reset_off();
        chk({ict, pins_oe}, 16'h00ff);
        results();
    end
endmodule // tb_top
`default_nettype wire
